// ===== fwsr_host.sv
// host-side poller for flash program/erase status, apb register front end
//
// Functional notes
// - host polls at the program address or an erasing sector address
// - after poll bit turns true, host reads the whole word once more
// - toggle polling starts with two reads; no change means done
// - still toggling with timeout flag set: check again, then fail and reset
// - resumed polling reads once more and compares with the previous read
// - host rechecks poll bit even when timeout flag is seen
//
// Our own choices: the address map and register access over APB.
`include "fwsr_defines.svh"
`default_nettype none
module fwsr_host (
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output fwsr_pkg::fwsr_pins_t flash,
  input wire logic [15:0] flash_dq_in,
  input wire logic ready_busy_n
);

  fwsr_pkg::fwsr_state_t state_r, state_nxt;
  fwsr_pkg::fwsr_mode_t mode_r;
  logic [21:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic [15:0] first_r, first_nxt;
  logic chk_r, chk_nxt;
  logic done_r, pass_r, fail_r, tmo_r;
  logic rdy_r, sectog_r, acttog_r;
  logic inflight_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic fin_pass, fin_fail;
  fwsr_pkg::fwsr_req_t req;
  logic cyc_done;
  logic [15:0] cyc_rd;

  // apb decode: one wait state, writes land on the completing edge
  wire logic acc = psel && penable;
  wire logic wr_fire = acc && pready_r && pwrite;
  wire logic hit_ctrl = (paddr == `FWSR_OFF_CTRL);
  wire logic hit_addr = (paddr == `FWSR_OFF_ADDR);
  wire logic hit_wdata = (paddr == `FWSR_OFF_WDATA);
  wire logic hit_status = (paddr == `FWSR_OFF_STATUS);
  wire logic hit_rdata = (paddr == `FWSR_OFF_RDATA);
  wire logic hit_any = hit_ctrl || hit_addr || hit_wdata || hit_status || hit_rdata;
  wire logic idle = (state_r == fwsr_pkg::FWSR_S_IDLE);
  wire logic start = wr_fire && hit_ctrl && pwdata[`FWSR_CTRL_START] && idle;
  wire logic st_clr = wr_fire && hit_status;

  wire logic [31:0] status_word = {24'h000000, acttog_r, sectog_r, rdy_r, tmo_r,
                                   fail_r, pass_r, done_r, !idle};
  wire logic [31:0] rd_mux =
      hit_ctrl ? {29'h00000000, mode_r, 1'b0} :
      hit_addr ? {10'h000, addr_r} :
      hit_wdata ? {16'h0000, wdata_r} :
      hit_status ? status_word :
      hit_rdata ? {16'h0000, rdata_r} : 32'h00000000;

  // polling decisions on each finished read
  wire logic poll_true = (cyc_rd[`FWSR_BIT_POLL] == wdata_r[`FWSR_BIT_POLL]);
  wire logic act_tog = cyc_rd[`FWSR_BIT_ACT] ^ first_r[`FWSR_BIT_ACT];
  wire logic tmo_bit = cyc_rd[`FWSR_BIT_TMO];
  // only a status read counts: array data may carry any value in bit 5
  wire logic st_poll = (state_r == fwsr_pkg::FWSR_S_RD_FIRST) &&
                       (mode_r != fwsr_pkg::FWSR_M_TOGGLE_POLL) && !poll_true;
  wire logic st_tog = (state_r == fwsr_pkg::FWSR_S_RD_NEXT) && act_tog;
  wire logic tmo_seen = cyc_done && tmo_bit && (st_poll || st_tog);

  // request to the cycle engine; the engine is free whenever nothing is in flight
  wire logic rst_st = (state_r == fwsr_pkg::FWSR_S_RST);
  assign req.wr = rst_st || (state_r == fwsr_pkg::FWSR_S_WR);
  assign req.addr = rst_st ? `FWSR_RST_CMD_ADDR : addr_r;
  assign req.data = rst_st ? `FWSR_RST_CMD_DATA : wdata_r;
  wire logic req_valid = !idle && !inflight_r;

  fwsr_cycle u_cycle (
    .clk(clk),
    .srst(srst),
    .en(en),
    .req_valid(req_valid),
    .req(req),
    .dq_in(flash_dq_in),
    .pins(flash),
    .done(cyc_done),
    .rdata(cyc_rd)
  );

  // sequencer; every polling start begins with a fresh first read, single read and single write go straight to their one cycle
  always_comb begin
    state_nxt = state_r;
    first_nxt = first_r;
    chk_nxt = chk_r;
    fin_pass = 1'b0;
    fin_fail = 1'b0;
    case (state_r)
      fwsr_pkg::FWSR_S_IDLE: begin
        if (start) begin
          chk_nxt = 1'b0;
          case (fwsr_pkg::fwsr_mode_t'(pwdata[`FWSR_CTRL_MODE_HI:`FWSR_CTRL_MODE_LO]))
            fwsr_pkg::FWSR_M_SINGLE_RD: state_nxt = fwsr_pkg::FWSR_S_RD_FINAL;
            fwsr_pkg::FWSR_M_SINGLE_WR: state_nxt = fwsr_pkg::FWSR_S_WR;
            default: state_nxt = fwsr_pkg::FWSR_S_RD_FIRST;
          endcase
        end
      end
      fwsr_pkg::FWSR_S_RD_FIRST: begin
        if (cyc_done) begin
          if (mode_r == fwsr_pkg::FWSR_M_TOGGLE_POLL) begin
            first_nxt = cyc_rd;
            state_nxt = fwsr_pkg::FWSR_S_RD_NEXT;
          end else if (poll_true) begin
            state_nxt = fwsr_pkg::FWSR_S_RD_FINAL;
          end else if (chk_r) begin
            state_nxt = fwsr_pkg::FWSR_S_RST;
          end else if (tmo_bit) begin
            chk_nxt = 1'b1;
          end
        end
      end
      fwsr_pkg::FWSR_S_RD_NEXT: begin
        if (cyc_done) begin
          first_nxt = cyc_rd;
          if (!act_tog) begin
            state_nxt = fwsr_pkg::FWSR_S_IDLE;
            fin_pass = 1'b1;
          end else if (chk_r) begin
            state_nxt = fwsr_pkg::FWSR_S_RST;
          end else if (tmo_bit) begin
            chk_nxt = 1'b1;
          end
        end
      end
      fwsr_pkg::FWSR_S_RD_FINAL, fwsr_pkg::FWSR_S_WR: begin
        if (cyc_done) begin
          state_nxt = fwsr_pkg::FWSR_S_IDLE;
          fin_pass = 1'b1;
        end
      end
      fwsr_pkg::FWSR_S_RST: begin
        if (cyc_done) begin
          state_nxt = fwsr_pkg::FWSR_S_IDLE;
          fin_fail = 1'b1;
        end
      end
      default: state_nxt = fwsr_pkg::FWSR_S_IDLE;
    endcase
  end

  // sequencer state and engine handshake
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= fwsr_pkg::FWSR_S_IDLE;
      first_r <= `FWSR_DATA_RST;
      chk_r <= 1'b0;
      inflight_r <= 1'b0;
    end else if (en) begin
      state_r <= state_nxt;
      first_r <= first_nxt;
      chk_r <= chk_nxt;
      inflight_r <= req_valid || (inflight_r && !cyc_done);
    end
  end

  // software registers; reconfiguring is refused while a sequence runs
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r <= fwsr_pkg::FWSR_M_DATA_POLL;
      addr_r <= `FWSR_ADDR_RST;
      wdata_r <= `FWSR_DATA_RST;
    end else if (en && wr_fire && idle) begin
      if (hit_ctrl) mode_r <= fwsr_pkg::fwsr_mode_t'(pwdata[`FWSR_CTRL_MODE_HI:`FWSR_CTRL_MODE_LO]);
      if (hit_addr) addr_r <= pwdata[21:0];
      if (hit_wdata) wdata_r <= pwdata[15:0];
    end
  end

  // sticky results, write one to clear; a finish in the clear cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      done_r <= 1'b0;
      pass_r <= 1'b0;
      fail_r <= 1'b0;
      tmo_r <= 1'b0;
    end else if (en) begin
      done_r <= (fin_pass || fin_fail) || (done_r && !(st_clr && pwdata[`FWSR_ST_DONE]));
      pass_r <= fin_pass || (pass_r && !(st_clr && pwdata[`FWSR_ST_PASS]));
      fail_r <= fin_fail || (fail_r && !(st_clr && pwdata[`FWSR_ST_FAIL]));
      tmo_r <= tmo_seen || (tmo_r && !(st_clr && pwdata[`FWSR_ST_TMO]));
    end
  end

  // live status: busy pin level and toggle observations of the last pair
  always_ff @(posedge clk) begin
    if (srst) begin
      rdy_r <= 1'b1;
      sectog_r <= 1'b0;
      acttog_r <= 1'b0;
      rdata_r <= `FWSR_DATA_RST;
    end else if (en) begin
      rdy_r <= ready_busy_n;
      if (cyc_done && !req.wr) rdata_r <= cyc_rd;
      if (cyc_done && state_r == fwsr_pkg::FWSR_S_RD_NEXT) begin
        acttog_r <= act_tog;
        sectog_r <= cyc_rd[`FWSR_BIT_SECTOG] ^ first_r[`FWSR_BIT_SECTOG];
      end
    end
  end

  // apb answer registered so all outputs come from flops
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (en) begin
      pready_r <= acc && !pready_r;
      pslverr_r <= acc && !pready_r && !hit_any;
      if (acc && !pready_r) prdata_r <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule : fwsr_host
`default_nettype wire

// ===== fwsr_defines.svh
// offsets, field positions, reset values and timing counts of the flash status poller
`ifndef FWSR_DEFINES_SVH
`define FWSR_DEFINES_SVH

// apb register offsets (byte addresses, one word each)
`define FWSR_OFF_CTRL 8'h00
`define FWSR_OFF_ADDR 8'h04
`define FWSR_OFF_WDATA 8'h08
`define FWSR_OFF_STATUS 8'h0c
`define FWSR_OFF_RDATA 8'h10

// ctrl fields
`define FWSR_CTRL_START 0
`define FWSR_CTRL_MODE_LO 1
`define FWSR_CTRL_MODE_HI 2

// status fields
`define FWSR_ST_BUSY 0
`define FWSR_ST_DONE 1
`define FWSR_ST_PASS 2
`define FWSR_ST_FAIL 3
`define FWSR_ST_TMO 4
`define FWSR_ST_RDY 5
`define FWSR_ST_SECTOG 6
`define FWSR_ST_ACTTOG 7

// flash data bit positions
`define FWSR_BIT_POLL 7
`define FWSR_BIT_ACT 6
`define FWSR_BIT_TMO 5
`define FWSR_BIT_SECTOG 2

// widths and reset values
`define FWSR_AW 22
`define FWSR_DW 16
`define FWSR_ADDR_RST 22'h000000
`define FWSR_DATA_RST 16'h0000
`define FWSR_RST_CMD_DATA 16'h00f0
`define FWSR_RST_CMD_ADDR 22'h000000

// bus cycle timing, 250 MHz clock
`define FWSR_CLK_PS 4000
`define FWSR_T_RD_NS 70
`define FWSR_T_WP_NS 35
`define FWSR_T_REC_NS 20
`define FWSR_RD_CYC ((`FWSR_T_RD_NS * 1000 + `FWSR_CLK_PS - 1) / `FWSR_CLK_PS)
`define FWSR_WP_CYC ((`FWSR_T_WP_NS * 1000 + `FWSR_CLK_PS - 1) / `FWSR_CLK_PS)
`define FWSR_REC_CYC ((`FWSR_T_REC_NS * 1000 + `FWSR_CLK_PS - 1) / `FWSR_CLK_PS)

`endif

// ===== fwsr_pkg.sv
// types shared by the flash status poller
`default_nettype none
package fwsr_pkg;

  typedef enum logic [5:0] {
    FWSR_S_IDLE = 6'b000001,
    FWSR_S_RD_FIRST = 6'b000010,
    FWSR_S_RD_NEXT = 6'b000100,
    FWSR_S_RD_FINAL = 6'b001000,
    FWSR_S_WR = 6'b010000,
    FWSR_S_RST = 6'b100000
  } fwsr_state_t;

  typedef enum logic [1:0] {
    FWSR_M_DATA_POLL = 2'h0,
    FWSR_M_TOGGLE_POLL = 2'h1,
    FWSR_M_SINGLE_RD = 2'h2,
    FWSR_M_SINGLE_WR = 2'h3
  } fwsr_mode_t;

  // flash-side pins driven by the host
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [21:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } fwsr_pins_t;

  // one bus cycle request to the cycle engine
  typedef struct packed {
    logic wr;
    logic [21:0] addr;
    logic [15:0] data;
  } fwsr_req_t;

endpackage : fwsr_pkg
`default_nettype wire

// ===== fwsr_cycle.sv
// single flash read or write bus cycle with fixed strobe and recovery times
`include "fwsr_defines.svh"
`default_nettype none
module fwsr_cycle (
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  input wire logic req_valid,
  input wire fwsr_pkg::fwsr_req_t req,
  input wire logic [15:0] dq_in,
  output fwsr_pkg::fwsr_pins_t pins,
  output logic done,
  output logic [15:0] rdata
);

  logic busy_r;
  logic phase_r;
  logic [7:0] cnt_r;
  fwsr_pkg::fwsr_pins_t pins_r;
  logic done_r;
  logic [15:0] rdata_r;

  wire logic take = req_valid && !busy_r;
  wire logic last = (cnt_r <= 8'h01);
  wire logic [7:0] strobe_cyc = req.wr ? 8'(`FWSR_WP_CYC) : 8'(`FWSR_RD_CYC);

  // strobe phase then recovery phase; write data stays driven through recovery
  // because the device latches it on the rising write strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      phase_r <= 1'b0;
      cnt_r <= 8'h00;
      pins_r <= '{1'b1, 1'b1, 1'b1, `FWSR_ADDR_RST, `FWSR_DATA_RST, 1'b0};
      done_r <= 1'b0;
      rdata_r <= `FWSR_DATA_RST;
    end else if (en) begin
      done_r <= 1'b0;
      if (take) begin
        busy_r <= 1'b1;
        phase_r <= 1'b0;
        cnt_r <= strobe_cyc;
        pins_r <= '{1'b0, req.wr, !req.wr, req.addr, req.data, req.wr};
      end else if (busy_r && !last) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (busy_r && !phase_r) begin
        phase_r <= 1'b1;
        cnt_r <= 8'(`FWSR_REC_CYC);
        if (!pins_r.oe_n) rdata_r <= dq_in; // sampled before the strobe rises
        pins_r.ce_n <= 1'b1;
        pins_r.oe_n <= 1'b1;
        pins_r.we_n <= 1'b1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        pins_r.dq_oe <= 1'b0;
      end
    end
  end

  assign pins = pins_r;
  assign done = done_r;
  assign rdata = rdata_r;

endmodule : fwsr_cycle
`default_nettype wire

// ===== fwsr_checker.sv
// assertions on the apb and flash pins of the status poller
`default_nettype none
module fwsr_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fwsr_pkg::fwsr_pins_t flash
);
  // en low freezes every flop, so no count is meaningful across it
  default clocking @(posedge clk); endclocking
  default disable iff (srst || !en);
  sequence rd_low8; (!flash.oe_n && !flash.ce_n)[*8]; endsequence
  sequence wr_low8; (!flash.we_n && flash.dq_oe)[*8]; endsequence
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  chk_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  chk_unmapped_err: assert property (psel && penable && !pready && !pwrite && paddr > 8'h10
    |=> pslverr && prdata == 32'h0) else $error("unmapped read accepted");
  chk_read_len: assert property ($fell(flash.oe_n) |-> rd_low8 ##1 rd_low8 ##1
    (!flash.oe_n)[*2] ##1 flash.oe_n) else $error("read strobe length");
  chk_write_len: assert property ($fell(flash.we_n) |-> wr_low8 ##1 !flash.we_n ##1
    (flash.we_n && flash.dq_oe)) else $error("write strobe length");
  chk_no_fight: assert property (!flash.oe_n |-> !flash.dq_oe && flash.we_n)
    else $error("host drives during read");
  chk_addr_hold: assert property (!flash.ce_n && !$past(flash.ce_n)
    |-> $stable(flash.addr)) else $error("address moved in cycle");
  chk_read_recovery: assert property ($rose(flash.oe_n) |-> flash.oe_n[*5])
    else $error("read recovery short");
endmodule : fwsr_checker
bind fwsr_host fwsr_checker u_chk (.clk(clk), .srst(srst), .en(en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flash(flash));
`default_nettype wire

// ===== fwsr_flash_model.sv
// behavioural flash die answering status reads and commands
`default_nettype none
module fwsr_flash_model (
  input wire logic clk,
  input wire fwsr_pkg::fwsr_pins_t pins,
  output logic [15:0] dq,
  output logic rb_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] word = 16'h0000;
  logic [15:0] last_wd = 16'h0000;
  logic [21:0] vaddr = 22'h000000;
  logic [21:0] last_wa = 22'h000000;
  logic act = 1'b0, sec = 1'b0, er = 1'b0, stuck = 1'b0, tmo = 1'b0, rd_on = 1'b0;
  logic susp = 1'b0;
  int busy = 0, nrd = 0, bad = 0, nwr = 0, tleft = 0;
  // load an operation as if its command sequence just ended
  task automatic arm(input int n, input logic [15:0] w, input logic e, input logic s,
                     input logic [21:0] a);
    busy = n;
    word = w;
    er = e;
    stuck = s;
    tmo = s;
    vaddr = a;
    nrd = 0;
    bad = 0;
    susp = 1'b0;
    tleft = 0;
  endtask : arm
  // protected target: busy for a fixed time, then the unchanged array data
  task automatic arm_prot(input int t, input logic [15:0] w, input logic e,
                          input logic [21:0] a);
    arm(1, w, e, 1'b1, a);
    tmo = 1'b0;
    tleft = t;
  endtask : arm_prot
  // erase suspended: status stays, the activity bit freezes
  task automatic arm_susp(input logic [15:0] w, input logic [21:0] a);
    arm(1, w, 1'b1, 1'b1, a);
    tmo = 1'b0;
    susp = 1'b1;
  endtask : arm_susp
  assign rb_oe = busy != 0 && !susp;
  initial dq = 16'h0000;
  // status bits as the die shows them while an operation runs
  wire logic [15:0] stat_word = {word[15:8], susp | (!er & ~word[7]), act, tmo,
                                 word[4], er | word[3], er ? sec : word[2], word[1:0]};
  // status at the operation's address while busy, array data elsewhere or when idle;
  // a released bus flips every cycle; the protected-target timer counts here
  always @(posedge clk) begin
    if (tleft != 0) begin
      tleft--;
      if (tleft == 0) busy = 0;
    end
    if (!pins.ce_n && !pins.oe_n)
      dq <= (busy != 0 && pins.addr == vaddr) ? stat_word : word;
    else
      dq <= ~dq;
  end
  always @(negedge pins.oe_n) rd_on = 1'b1;
  // one advance per finished read, whichever strobe ends it
  always @(posedge pins.oe_n or posedge pins.ce_n) begin
    if (rd_on) begin
      rd_on = 1'b0;
      nrd++;
      if (busy != 0 && pins.addr != vaddr) bad++;
      if (busy != 0) begin
        if (!susp) act = ~act;
        sec = ~sec;
        if (!stuck) busy--;
      end
    end
  end
  // the reset command ends any operation and clears the flag
  always @(posedge pins.we_n) begin
    nwr++;
    last_wa = pins.addr;
    last_wd = pins.dq_out;
    if (pins.dq_out == 16'h00f0) begin
      busy = 0;
      tmo = 1'b0;
    end
  end
endmodule : fwsr_flash_model
`default_nettype wire

// ===== fwsr_host_tb_top.sv
// self-checking bench for the flash status poller
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module fwsr_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, rb_oe, fl;
  logic [15:0] dev_dq, w;
  logic [21:0] a;
  fwsr_pkg::fwsr_pins_t flash;
  wire logic [15:0] dq_wire = flash.dq_oe ? flash.dq_out : dev_dq;
  wire logic rb_n = !rb_oe; // pull-up wins unless pulled low
  int fails = 0, total_checks = 0, cyc = 0, seed = 32'hbb49ad7b, n, k, k0, t, c0;
  localparam int prot_erase_cyc = 25000; // about 100 us of 4 ns cycles
  localparam int prot_prog_cyc = 250; // about 1 us
  fwsr_host u_dut (.clk(clk), .srst(srst), .en(en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash(flash), .flash_dq_in(dq_wire), .ready_busy_n(rb_n));
  fwsr_flash_model u_dev (.clk(clk), .pins(flash), .dq(dev_dq), .rb_oe(rb_oe));
  always #2 clk = ~clk;
  // a hung handshake ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // start one sequence, then poll until the busy bit drops
  task automatic seq(input logic [1:0] m, input logic [21:0] ad, input logic [15:0] d);
    apb(1'b1, 8'h0c, 32'h0000001e);
    apb(1'b1, 8'h04, {10'h000, ad});
    apb(1'b1, 8'h08, {16'h0000, d});
    apb(1'b1, 8'h00, {29'h0, m, 1'b1});
    k = 0;
    do begin
      apb(1'b0, 8'h0c, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 8000);
    `CHK("poll finished", 1'b0, rd[0])
  endtask : seq
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("idle status", 32'h00000020, rd)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    apb(1'b1, 8'h04, 32'hffffffff);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("addr width", 32'h003fffff, rd)
    // a short enable gap while idle
    en <= 1'b0;
    repeat (3) @(posedge clk);
    en <= 1'b1;
    // modes 0 and 1, each with program, erase and a stuck operation
    for (int s = 0; s < 6; s++) begin
      n = 1 + ($random(seed) & 3);
      w = 16'($random(seed));
      a = 22'($random(seed));
      if (s % 3 == 1) w[7] = 1'b1;
      fl = s % 3 == 2;
      if (!fl) w[5] = 1'b0; // array data must not look like a raised flag
      u_dev.arm(n, w, s % 3 == 1, fl, a);
      k0 = u_dev.nwr;
      seq(2'(s / 3), a, w);
      `CHK("outcome", {fl, !fl, 1'b1}, rd[3:1])
      `CHK("flag and pin", {1'b1, fl}, rd[5:4])
      `CHK("off-address reads", 0, u_dev.bad)
      `CHK("commands", fl ? 1 : 0, u_dev.nwr - k0)
      if (fl) `CHK("reset cmd", {22'h0, 16'h00f0}, {u_dev.last_wa, u_dev.last_wd})
      if (s == 3 || s == 4) `CHK("pair changed", 2'b00, rd[7:6])
      if (s < 3) `CHK("read count", fl ? 2 : n + 2, u_dev.nrd)
      apb(1'b0, 8'h10, 32'h0);
      if (s % 3 != 2) `CHK("rdata", {16'h0, w}, rd)
    end
    // protected targets: busy for a fixed time, then the old array data
    for (int p = 0; p < 2; p++) begin
      w = 16'($random(seed)) | 16'h0080;
      w[5] = 1'b0;
      a = 22'($random(seed));
      t = p ? prot_prog_cyc : prot_erase_cyc;
      u_dev.arm_prot(t, w, p == 0, a);
      c0 = cyc;
      seq(2'(p), a, w);
      `CHK("protected outcome", 3'b001, rd[4:2])
      `CHK("protected time", 1'b1, (cyc - c0 >= t) && (cyc - c0 < t + 200))
      apb(1'b0, 8'h10, 32'h0);
      `CHK("protected data", {16'h0, w}, rd)
    end
    // erase suspended: only the sector toggle bit moves and the pin reads ready
    w = 16'($random(seed)) & 16'hffdf;
    u_dev.arm_susp(w, a);
    seq(2'h1, a, w);
    `CHK("suspend status", 7'b0110011, rd[7:1])
    // a single read while erasing returns the erase status bits
    u_dev.arm(2, w, 1'b1, 1'b0, a);
    seq(2'h2, a, 16'h0);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("erase status bits", 2'b01, {rd[7], rd[3]})
    u_dev.arm(3, 16'h1234, 1'b0, 1'b0, 22'h0);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("pin busy", 1'b0, rd[5])
    w = 16'($random(seed));
    seq(2'h3, 22'h00abc, w);
    `CHK("write", {22'h00abc, w}, {u_dev.last_wa, u_dev.last_wd})
    u_dev.arm(0, ~w, 1'b0, 1'b0, 22'h0);
    seq(2'h2, 22'h01234, 16'h0);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("array read", {16'h0, ~w}, rd)
    results();
  end
endmodule : fwsr_host_tb_top
`default_nettype wire
